// file: host_link_model.sv
// host that wakes the device and sends a burst
`timescale 1ns/10ps
module host_link_model (
  input logic clock_in,
  input logic resetn_in,
  input logic start_in,       // begin a burst
  input logic [3:0] bytes_in, // burst length
  input logic flow_ready_in,  // device flow control
  output logic wake_out,           // wake pin level
  output logic busy_out            // burst under way
);
  logic [3:0] left_q; // bytes still to send
  // wake first, bytes only on ready
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wake_out <= 1'b0;
      busy_out <= 1'b0;
      left_q <= 4'h0;
    end else if (start_in && !busy_out) begin
      wake_out <= 1'b1;
      busy_out <= 1'b1;
      left_q <= bytes_in;
    end else if (busy_out && flow_ready_in && left_q != 4'h0) begin
      left_q <= left_q - 4'h1;
    end else if (busy_out && left_q == 4'h0) begin
      wake_out <= 1'b0;
      busy_out <= 1'b0;
    end
  end
endmodule

// file: pmw_pkg.sv
// package of constants for the power mode and wake controller
package pmw_pkg;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] ctrl_addr = 8'h00;      // control register
  localparam logic [7:0] status_addr = 8'h04;    // status register
  localparam logic [7:0] wake_cfg_addr = 8'h08;  // wake pin mapping
  localparam logic [7:0] gpio_cfg_addr = 8'h0C;  // gpio interrupt enables
  localparam logic [7:0] rtc_sub_addr = 8'h10;   // sub-second count
  localparam logic [7:0] rtc_sec_addr = 8'h14;   // seconds count
  localparam logic [7:0] rtc_alarm_addr = 8'h18; // alarm second
  localparam logic [7:0] rtc_period_addr = 8'h1C; // periodic wake period
  localparam logic [7:0] event_done_addr = 8'h20; // handler done strobe
  localparam logic [7:0] reset_cause_addr = 8'h24; // reset cause

  // ************************************************************
  // control field positions and reset values
  // ************************************************************
  localparam int ctrl_sleep_en_bit = 0;    // allow deep sleep
  localparam int ctrl_alarm_en_bit = 1;    // enable alarm wake
  localparam int ctrl_period_en_bit = 2;   // enable periodic wake
  localparam int ctrl_wdog_kick_bit = 3;   // write 1 to kick watchdog
  localparam logic [31:0] ctrl_reset = 32'h0000_0000;
  localparam logic [31:0] wake_cfg_reset = 32'h0000_0000;
  localparam logic [31:0] gpio_cfg_reset = 32'h0000_0000;
  localparam logic [31:0] period_reset = 32'h0000_0001;

  // ************************************************************
  // gpio and channel sizes
  // ************************************************************
  localparam int gpio_count = 16;        // gpio pins handled
  localparam int irq_channels = 4;       // shared interrupt channels

  // ************************************************************
  // timing
  // ************************************************************
  localparam int clk_hz = 20_000_000;            // system clock rate
  localparam int wake_delay_us = 100;            // clock settle time
  localparam int wake_delay_cycles = (wake_delay_us * (clk_hz / 1_000_000));
  localparam int reset_pulse_us = 10;            // internal reset pulse
  localparam int reset_pulse_cycles = (reset_pulse_us * (clk_hz / 1_000_000));
  localparam int subsec_per_sec = 32768;         // sub-second ticks per second
  localparam int wdog_default = 1_000_000;       // watchdog length in cycles

  // power states
  typedef enum logic [1:0] {
    pwr_active = 2'b00,
    pwr_light = 2'b01,
    pwr_deep = 2'b10,
    pwr_waking = 2'b11
  } pwr_state_t;

endpackage

// file: pmw_rtc.sv
// real-time clock with sub-second count, alarm and periodic wake
`timescale 1ns/10ps
module pmw_rtc (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic tick_in,         // one slow-crystal tick
  input wire logic sec_wr_in,       // load seconds
  input wire logic [31:0] sec_wdata_in,
  input wire logic [31:0] alarm_in,
  input wire logic [31:0] period_in,
  input wire logic alarm_en_in,
  input wire logic period_en_in,
  output logic [31:0] subsec_out,
  output logic [31:0] sec_out,
  output logic wake_out             // one-cycle wake pulse
);
  logic [31:0] sub_q;   // sub-second counter
  logic [31:0] sec_q;   // seconds counter
  logic [31:0] pcnt_q;  // periodic counter
  logic wake_q;         // registered wake pulse
  wire sec_roll_w = tick_in && (sub_q == 32'(pmw_pkg::subsec_per_sec - 1));
  wire period_hit_w = period_en_in && sec_roll_w && (pcnt_q + 32'h1 >= period_in);
  wire alarm_hit_w = alarm_en_in && sec_roll_w && (sec_q + 32'h1 == alarm_in);

  // counters keep running in every power state
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sub_q <= 32'h0;
      sec_q <= 32'h0;
      pcnt_q <= 32'h0;
      wake_q <= 1'b0;
    end else begin
      if (tick_in) begin
        sub_q <= sec_roll_w ? 32'h0 : sub_q + 32'h1;
      end
      if (sec_wr_in) begin
        sec_q <= sec_wdata_in;
      end else if (sec_roll_w) begin
        sec_q <= sec_q + 32'h1;
      end
      if (period_hit_w) begin
        pcnt_q <= 32'h0;
      end else if (sec_roll_w) begin
        pcnt_q <= pcnt_q + 32'h1;
      end
      wake_q <= period_hit_w || alarm_hit_w;
    end
  end

  assign subsec_out = sub_q;
  assign sec_out = sec_q;
  assign wake_out = wake_q;
endmodule

// file: pmw_sync.sv
// two flip-flop synchronisers for every pin input
`timescale 1ns/10ps
module pmw_sync (
  input wire logic clock_in,
  input wire logic resetn_in,
  pmw_sync_if.sync_side pins
);
  localparam int w = pmw_pkg::gpio_count + 2;
  logic [w-1:0] stage1_q; // first stage, read only by second
  logic [w-1:0] stage2_q; // second stage
  wire [w-1:0] raw_w = {pins.rst_pin_raw, pins.radio_raw, pins.gpio_raw};

  // two stage capture
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= raw_w;
      stage2_q <= stage1_q;
    end
  end

  assign pins.gpio_sync = stage2_q[pmw_pkg::gpio_count-1:0];
  assign pins.radio_sync = stage2_q[pmw_pkg::gpio_count];
  assign pins.rst_pin_sync = stage2_q[pmw_pkg::gpio_count+1];
endmodule

// file: pmw_sync_if.sv
// synchronised pins between controller and sync stage
`timescale 1ns/10ps
interface pmw_sync_if;
  logic [pmw_pkg::gpio_count-1:0] gpio_raw;  // raw gpio pins
  logic [pmw_pkg::gpio_count-1:0] gpio_sync; // synchronised gpio
  logic radio_raw;                           // raw radio activity
  logic radio_sync;                          // synchronised radio
  logic rst_pin_raw;                         // raw reset pin level
  logic rst_pin_sync;                        // synchronised reset pin
  modport sync_side (input gpio_raw, input radio_raw, input rst_pin_raw,
    output gpio_sync, output radio_sync, output rst_pin_sync);
  modport user_side (output gpio_raw, output radio_raw, output rst_pin_raw,
    input gpio_sync, input radio_sync, input rst_pin_sync);
endinterface

// file: power_mode_wake_control.sv
// power state, wake and reset controller with an AXI4-Lite register port
// Contract
// - light sleep halts only the core
// - deep sleep stops clocks and serial port
// - wait clock settle delay after deep wake
// - wake pin high forces and holds awake
// - gpio, radio, rtc events wake deep sleep
// - gpio wake returns to sleep after handling
// - wake function mapped to one gpio
// - flow control inactive until fully awake
// - no serial command wakes the device
// - memory retained in every power state
// - reset from pin, power-up or watchdog
// - internal reset pulses reset pin low
// - gpio interrupts share four channels modulo four
// - rtc runs always and can wake
// - rtc calendar, periodic and alarm wakes (the rtc keeps only sub-second and seconds counts, no calendar)
// - rtc crystal runs whenever powered
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
module power_mode_wake_control #(
  parameter int wdog_cycles = pmw_pkg::wdog_default,
  parameter int wake_delay = pmw_pkg::wake_delay_cycles
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic por_in,                 // internal power-up reset request
  input wire logic cpu_idle_in,            // core has nothing to run
  input wire logic rtc_tick_in,            // slow crystal tick, same clock
  input wire logic [pmw_pkg::gpio_count-1:0] gpio_in,
  input wire logic radio_activity_in,
  input wire logic reset_pin_in,           // level of the reset pad
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // power outputs
  output logic core_clk_en_out,            // processor core clock enable
  output logic sys_clk_en_out,             // system and peripheral clocks
  output logic uart_en_out,                // serial port enable
  output logic radio_pwr_out,              // radio supply
  output logic ram_retain_out,             // working memory retention
  output logic flow_ready_out,             // serial flow control, high when ready
  output logic event_irq_out,              // wake event pending for the core
  output logic reset_pin_out,              // reset pad output value
  output logic reset_pin_oe_n_out,         // reset pad enable, low drives
  output logic sys_reset_n_out             // merged system reset
);

  // ************************************************************
  // synchronised pins
  // ************************************************************
  pmw_sync_if pins ();
  assign pins.gpio_raw = gpio_in;
  assign pins.radio_raw = radio_activity_in;
  assign pins.rst_pin_raw = reset_pin_in;
  pmw_sync u_sync (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .pins(pins)
  );

  // ************************************************************
  // registers
  // ************************************************************
  logic [31:0] ctrl_q;      // control
  logic [31:0] wake_cfg_q;  // wake pin gpio index
  logic [31:0] gpio_cfg_q;  // gpio interrupt enables
  logic [31:0] alarm_q;     // alarm second
  logic [31:0] period_q;    // periodic wake seconds
  logic [1:0] cause_q;      // last reset cause: 1 power, 2 watchdog, 0 only after resetn_in; a pin reset leaves it unchanged
  pmw_pkg::pwr_state_t state_q;
  logic [31:0] delay_q;     // wake settle counter
  logic [31:0] wdog_q;      // watchdog counter
  logic [31:0] rst_cnt_q;   // internal reset pulse counter
  logic [pmw_pkg::gpio_count-1:0] gpio_prev_q;
  logic pending_q;          // wake event awaiting handler
  logic [pmw_pkg::irq_channels-1:0] chan_q; // sticky channel flags
  logic awake_hold_q;       // wake pin held
  logic sys_rst_n_q;
  logic rst_drive_q;
  logic aw_q, w_q, bvalid_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q, bresp_q;
  logic [9:0] outs_q;       // registered power outputs

  // ************************************************************
  // wake sources
  // ************************************************************
  wire [3:0] wake_idx_w = wake_cfg_q[3:0];
  wire wake_pin_w = pins.gpio_sync[wake_idx_w];
  wire [pmw_pkg::gpio_count-1:0] rise_w = pins.gpio_sync & ~gpio_prev_q;
  logic [pmw_pkg::irq_channels-1:0] chan_hit_w;
  genvar gc;
  generate
    for (gc = 0; gc < pmw_pkg::irq_channels; gc++) begin : g_chan
      logic acc;
      always_comb begin
        acc = 1'b0;
        for (int p = gc; p < pmw_pkg::gpio_count; p += pmw_pkg::irq_channels) begin
          acc = acc | (rise_w[p] & gpio_cfg_q[p] & (wake_idx_w != 4'(p)));
        end
      end
      assign chan_hit_w[gc] = acc;
    end
  endgenerate
  wire rtc_wake_w;
  wire event_w = (|chan_hit_w) || pins.radio_sync || rtc_wake_w;

  // ************************************************************
  // bus decode
  // ************************************************************
  wire wr_go_w = aw_q && w_q && !bvalid_q;
  wire rd_go_w = s_axi_arvalid && !rvalid_q;
  wire wr_ctrl_w = wr_go_w && awaddr_q == pmw_pkg::ctrl_addr;
  wire wr_done_w = wr_go_w && awaddr_q == pmw_pkg::event_done_addr && wdata_q[0];
  wire wr_sec_w = wr_go_w && awaddr_q == pmw_pkg::rtc_sec_addr;
  wire wr_known_w = awaddr_q inside {pmw_pkg::ctrl_addr, pmw_pkg::wake_cfg_addr,
    pmw_pkg::gpio_cfg_addr, pmw_pkg::rtc_sec_addr, pmw_pkg::rtc_alarm_addr,
    pmw_pkg::rtc_period_addr, pmw_pkg::event_done_addr};
  wire kick_w = wr_ctrl_w && wdata_q[pmw_pkg::ctrl_wdog_kick_bit];
  wire [31:0] subsec_w, sec_w;

  pmw_rtc u_rtc (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .tick_in(rtc_tick_in),
    .sec_wr_in(wr_sec_w),
    .sec_wdata_in(wdata_q),
    .alarm_in(alarm_q),
    .period_in(period_q),
    .alarm_en_in(ctrl_q[pmw_pkg::ctrl_alarm_en_bit]),
    .period_en_in(ctrl_q[pmw_pkg::ctrl_period_en_bit]),
    .subsec_out(subsec_w),
    .sec_out(sec_w),
    .wake_out(rtc_wake_w)
  );

  // read mux
  logic [31:0] rd_mux_w;
  logic rd_err_w;
  always_comb begin
    rd_err_w = 1'b0;
    unique case (s_axi_araddr)
      pmw_pkg::ctrl_addr: rd_mux_w = ctrl_q;
      pmw_pkg::status_addr: rd_mux_w = {24'h0, chan_q, pending_q, awake_hold_q, state_q};
      pmw_pkg::wake_cfg_addr: rd_mux_w = wake_cfg_q;
      pmw_pkg::gpio_cfg_addr: rd_mux_w = gpio_cfg_q;
      pmw_pkg::rtc_sub_addr: rd_mux_w = subsec_w;
      pmw_pkg::rtc_sec_addr: rd_mux_w = sec_w;
      pmw_pkg::rtc_alarm_addr: rd_mux_w = alarm_q;
      pmw_pkg::rtc_period_addr: rd_mux_w = period_q;
      pmw_pkg::reset_cause_addr: rd_mux_w = {30'h0, cause_q};
      default: begin
        rd_mux_w = 32'h0;
        rd_err_w = 1'b1;
      end
    endcase
  end

  // ************************************************************
  // axi4-lite slave
  // ************************************************************
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      rdata_q <= 32'h0;
      rresp_q <= 2'h0;
      bresp_q <= 2'h0;
    end else begin
      // capture address and data in either order
      if (s_axi_awvalid && !aw_q) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
      if (wr_go_w) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_known_w ? 2'h0 : 2'h2;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (rd_go_w) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux_w;
        rresp_q <= rd_err_w ? 2'h2 : 2'h0;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // configuration registers, whole-word writes
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_q <= pmw_pkg::ctrl_reset;
      wake_cfg_q <= pmw_pkg::wake_cfg_reset;
      gpio_cfg_q <= pmw_pkg::gpio_cfg_reset;
      alarm_q <= 32'h0;
      period_q <= pmw_pkg::period_reset;
    end else if (wr_go_w && s_axi_wstrb != 4'h0) begin
      if (awaddr_q == pmw_pkg::ctrl_addr) ctrl_q <= wdata_q & 32'h0000_0007;
      if (awaddr_q == pmw_pkg::wake_cfg_addr) wake_cfg_q <= wdata_q & 32'h0000_000F;
      if (awaddr_q == pmw_pkg::gpio_cfg_addr) gpio_cfg_q <= wdata_q & 32'h0000_FFFF;
      if (awaddr_q == pmw_pkg::rtc_alarm_addr) alarm_q <= wdata_q;
      if (awaddr_q == pmw_pkg::rtc_period_addr) period_q <= wdata_q;
    end
  end

  // ************************************************************
  // power state machine
  // ************************************************************
  // deep sleep entry condition
  wire may_sleep_w = ctrl_q[pmw_pkg::ctrl_sleep_en_bit] && !wake_pin_w && !pending_q;
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= pmw_pkg::pwr_active;
      delay_q <= 32'h0;
      pending_q <= 1'b0;
      chan_q <= '0;
      gpio_prev_q <= '0;
      awake_hold_q <= 1'b0;
    end else begin
      gpio_prev_q <= pins.gpio_sync;
      awake_hold_q <= wake_pin_w;
      // event pending until handler done; set wins
      if (event_w) begin
        pending_q <= 1'b1;
      end else if (wr_done_w) begin
        pending_q <= 1'b0;
      end
      if (|chan_hit_w) begin
        chan_q <= chan_q | chan_hit_w;
      end else if (wr_done_w) begin
        chan_q <= '0;
      end
      unique case (state_q)
        pmw_pkg::pwr_active: begin
          if (may_sleep_w) state_q <= pmw_pkg::pwr_deep;
          else if (cpu_idle_in && !event_w) state_q <= pmw_pkg::pwr_light;
        end
        pmw_pkg::pwr_light: begin
          if (!cpu_idle_in || event_w) state_q <= pmw_pkg::pwr_active;
          else if (may_sleep_w) state_q <= pmw_pkg::pwr_deep;
        end
        pmw_pkg::pwr_deep: begin
          if (wake_pin_w || event_w) begin
            state_q <= pmw_pkg::pwr_waking;
            delay_q <= 32'(wake_delay);
          end
        end
        pmw_pkg::pwr_waking: begin
          if (delay_q <= 32'h1) state_q <= pmw_pkg::pwr_active;
          else delay_q <= delay_q - 32'h1;
        end
      endcase
    end
  end

  // ************************************************************
  // reset merge and watchdog
  // ************************************************************
  wire wdog_exp_w = (wdog_q == 32'h0);
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wdog_q <= 32'(wdog_cycles);
      rst_cnt_q <= 32'h0;
      cause_q <= 2'h0;
      sys_rst_n_q <= 1'b0;
      rst_drive_q <= 1'b0;
    end else begin
      // watchdog, power-up and pin reset sources
      if (kick_w || rst_cnt_q != 32'h0) wdog_q <= 32'(wdog_cycles);
      else if (!wdog_exp_w) wdog_q <= wdog_q - 32'h1;
      if (por_in || wdog_exp_w) begin
        rst_cnt_q <= 32'(pmw_pkg::reset_pulse_cycles);
        cause_q <= por_in ? 2'h1 : 2'h2;
      end else if (rst_cnt_q != 32'h0) begin
        rst_cnt_q <= rst_cnt_q - 32'h1;
      end
      // pulse reset pad during internal reset
      rst_drive_q <= por_in || wdog_exp_w || rst_cnt_q > 32'h1;
      sys_rst_n_q <= pins.rst_pin_sync && !(por_in || wdog_exp_w || rst_cnt_q != 32'h0);
    end
  end

  // ************************************************************
  // registered outputs
  // ************************************************************
  wire awake_w = state_q == pmw_pkg::pwr_active || state_q == pmw_pkg::pwr_light;
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      outs_q <= 10'h130;
    end else begin
      outs_q[0] <= state_q == pmw_pkg::pwr_active;   // core clock
      outs_q[1] <= awake_w;                           // system clocks
      outs_q[2] <= awake_w;                           // serial port
      outs_q[3] <= awake_w;                           // flow ready
      outs_q[4] <= 1'b1;                              // radio power
      outs_q[5] <= 1'b1;                              // memory retention
      outs_q[6] <= pending_q;
      outs_q[7] <= 1'b0;                              // pad drives low only
      outs_q[8] <= !rst_drive_q;                      // enable, low drives
      outs_q[9] <= sys_rst_n_q;
    end
  end

  assign core_clk_en_out = outs_q[0];
  assign sys_clk_en_out = outs_q[1];
  assign uart_en_out = outs_q[2];
  assign flow_ready_out = outs_q[3];
  assign radio_pwr_out = outs_q[4];
  assign ram_retain_out = outs_q[5];
  assign event_irq_out = outs_q[6];
  assign reset_pin_out = outs_q[7];
  assign reset_pin_oe_n_out = outs_q[8];
  assign sys_reset_n_out = outs_q[9];
  assign s_axi_awready = !aw_q;
  assign s_axi_wready = !w_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule

// file: power_mode_wake_control_properties.sv
// assertions on the controller ports
`timescale 1ns/10ps
module power_mode_wake_control_properties #(parameter int wake_delay = 5) (
  input logic clock_in,
  input logic resetn_in,
  input logic por_in,
  input logic [pmw_pkg::gpio_count-1:0] gpio_in,
  input logic radio_activity_in,
  input logic core_clk_en_out,
  input logic sys_clk_en_out,
  input logic uart_en_out,
  input logic radio_pwr_out,
  input logic ram_retain_out,
  input logic flow_ready_out,
  input logic reset_pin_oe_n_out,
  input logic sys_reset_n_out
);
  localparam int lim = wake_delay + 8; // settle time plus sync slack
  logic [7:0] low_q; // cycles flow control has been low, saturating
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  // count low cycles of flow control
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) low_q <= 8'hFF;
    else if (flow_ready_out) low_q <= 8'h00;
    else if (low_q != 8'hFF) low_q <= low_q + 8'h01;
  end
  a_light_keeps_clocks: assert property (!core_clk_en_out && sys_clk_en_out |-> uart_en_out)
    else $error("light sleep lost serial port");
  a_deep_all_off: assert property (!sys_clk_en_out |-> !uart_en_out && !core_clk_en_out)
    else $error("clock ran in deep sleep");
  a_wake_settle: assert property ($rose(flow_ready_out) |-> int'(low_q) >= wake_delay)
    else $error("flow ready too early");
  a_pin_holds_awake: assert property (gpio_in[0][*4] ##0 sys_clk_en_out |=> sys_clk_en_out)
    else $error("slept while wake pin held");
  a_radio_wakes: assert property (radio_activity_in[*3] |-> ##[0:lim] sys_clk_en_out)
    else $error("radio did not wake");
  a_power_kept: assert property (radio_pwr_out && ram_retain_out)
    else $error("power or retention dropped");
  a_por_resets: assert property ($rose(por_in) |-> ##[1:4] !sys_reset_n_out)
    else $error("no reset after power-up");
  a_pad_pulled: assert property ($rose(por_in) |-> ##[1:4] !reset_pin_oe_n_out)
    else $error("pad not driven on reset");
endmodule
bind power_mode_wake_control power_mode_wake_control_properties #(.wake_delay(wake_delay)) chk_u (.*);

// file: power_mode_wake_control_tb.sv
// self-checking bench for the controller
`timescale 1ns/10ps
module power_mode_wake_control_tb;
  localparam int wd_len = 3000; // shortened watchdog
  localparam int wk_len = 5; // shortened settle delay
  logic clock_in, resetn_in, por_in, cpu_idle_in, rtc_tick_in, radio_activity_in, reset_pin_in;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic core_clk_en_out, sys_clk_en_out, uart_en_out, radio_pwr_out, ram_retain_out;
  logic flow_ready_out, event_irq_out, reset_pin_out, reset_pin_oe_n_out, sys_reset_n_out;
  logic [15:0] gpio_in, noise_q; // pin levels, stray levels
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, prev; // bus data, last reads
  logic [3:0] s_axi_wstrb, nbytes;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [4:0] vld; // valid and ready drives
  logic pad_low, go, busy, wake; // external pull, host control
  int failures, compares, n, p;
  assign reset_pin_in = (reset_pin_oe_n_out | reset_pin_out) & !pad_low;
  assign gpio_in = {noise_q[15:1], wake};
  assign {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = vld;
  power_mode_wake_control #(.wdog_cycles(wd_len), .wake_delay(wk_len)) dut_u (.*);
  host_link_model host_u (.clock_in, .resetn_in, .start_in(go), .bytes_in(nbytes),
    .flow_ready_in(flow_ready_out), .wake_out(wake), .busy_out(busy));
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  always @(posedge clock_in) rtc_tick_in <= 1'($urandom);
  // hang guard
  initial begin
    repeat (20000) @(posedge clock_in);
    failures++;
    finish_test();
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one bus transfer, each channel closes on its handshake
  task automatic axi(input logic we, input logic [7:0] a, input logic [31:0] d);
    logic [4:0] o, t;
    @(posedge clock_in);
    o = we ? 5'h1C : 5'h03;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    while (o != 5'h00) begin
      vld <= o;
      @(negedge clock_in);
      t = o & {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid};
      rsp = we ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge clock_in);
      o = o & ~t;
    end
    vld <= 5'h00;
  endtask
  task automatic wait_deep();
    for (int i = 0; i < 60 && sys_clk_en_out !== 1'b0; i++) @(negedge clock_in);
  endtask
  task automatic wait_rst();
    while (sys_reset_n_out !== 1'b1) @(negedge clock_in);
  endtask
  initial begin
    {failures, compares, resetn_in, por_in, cpu_idle_in, radio_activity_in} = '0;
    {pad_low, go, nbytes, noise_q, vld} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    void'($urandom(32'h4669));
    repeat (2) @(posedge clock_in);
    resetn_in <= 1'b1;
    wait_rst();
    noise_q <= 16'($urandom) & 16'hFFFE;
    axi(1'b0, pmw_pkg::ctrl_addr, 32'h0);
    check(rd, pmw_pkg::ctrl_reset);
    axi(1'b0, 8'h3C, 32'h0);
    check(rsp, 2'h2); // unmapped word refused
    axi(1'b0, pmw_pkg::rtc_sub_addr, 32'h0);
    prev = rd;
    repeat (20) @(posedge clock_in);
    axi(1'b0, pmw_pkg::rtc_sub_addr, 32'h0);
    check(rd > prev, 1'b1);
    $display("test reset_values done");
    axi(1'b1, pmw_pkg::ctrl_addr, 32'h8);
    cpu_idle_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    check({core_clk_en_out, sys_clk_en_out, uart_en_out}, 3'h3);
    axi(1'b1, pmw_pkg::ctrl_addr, 32'h9);
    wait_deep();
    check({sys_clk_en_out, uart_en_out, flow_ready_out}, 3'h0);
    axi(1'b0, pmw_pkg::status_addr, 32'h0);
    check(rd[1:0], 2'h2);
    $display("test light_deep done");
    nbytes <= 4'($urandom_range(15, 1));
    go <= 1'b1;
    @(posedge clock_in);
    go <= 1'b0;
    for (n = 0; flow_ready_out !== 1'b1; n++) @(negedge clock_in);
    check(n >= wk_len, 1'b1);
    while (busy === 1'b1) @(negedge clock_in) check(flow_ready_out, 1'b1);
    wait_deep();
    check(sys_clk_en_out, 1'b0);
    $display("test host_wake done");
    for (int s = 0; s < 2; s++) begin
      p = $urandom_range(15, 1);
      noise_q <= 16'h0;
      axi(1'b1, pmw_pkg::gpio_cfg_addr, 32'h1 << p);
      wait_deep();
      if (s == 0) noise_q[p] <= 1'b1;
      else radio_activity_in <= 1'b1;
      repeat (3) @(posedge clock_in);
      noise_q <= 16'h0;
      radio_activity_in <= 1'b0;
      while (flow_ready_out !== 1'b1) @(negedge clock_in);
      check(event_irq_out, 1'b1);
      axi(1'b0, pmw_pkg::status_addr, 32'h0);
      check(rd[7:3], {(s == 0) ? 4'(1 << (p % 4)) : 4'h0, 1'b1});
      axi(1'b1, pmw_pkg::event_done_addr, 32'h1);
      wait_deep();
      check(sys_clk_en_out, 1'b0);
    end
    $display("test event_wake done");
    pad_low <= 1'b1;
    repeat (10) @(posedge clock_in);
    pad_low <= 1'b0;
    @(negedge clock_in);
    check({reset_pin_oe_n_out, sys_reset_n_out}, 2'h2);
    wait_rst();
    @(posedge clock_in);
    por_in <= 1'b1;
    @(posedge clock_in);
    por_in <= 1'b0;
    for (n = 0; n < 8 && reset_pin_oe_n_out !== 1'b0; n++) @(negedge clock_in);
    check({reset_pin_oe_n_out, sys_reset_n_out}, 2'h0);
    wait_rst();
    for (n = 0; n < wd_len + 400 && sys_reset_n_out !== 1'b0; n++) @(negedge clock_in);
    check({reset_pin_oe_n_out, sys_reset_n_out}, 2'h0);
    $display("test resets done");
    finish_test();
  end
endmodule
